//--- bench/oals_link_assertions.sv
// Checker on the serial link between receiver and serializer.
// Assumes it sits beside the link interface and samples on the receiver clock.
module oals_link_assertions (
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    input wire logic       serial_clock,
    input wire logic       conversion_start,
    input wire logic       rate_select_pin,
    input wire logic       echo_clock,
    input wire logic [7:0] lane
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev_sck;
    int   edges;
    // Serial clock edges since the last start pulse, so frame lengths can be judged.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_sck <= 1'b0;
            edges    <= 0;
        end else begin
            prev_sck <= serial_clock;
            edges    <= conversion_start ? 0 : edges + int'(serial_clock != prev_sck);
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_echo; echo_clock == serial_clock; endproperty
    a_echo: assert property (p_echo) else $error("echo clock off");
    property p_sdr_hold; !rate_select_pin && $rose(serial_clock) |-> $stable(lane); endproperty
    a_sdr_hold: assert property (p_sdr_hold) else $error("lane moved on rise");
    property p_sck_half; $rose(serial_clock) |=> serial_clock ##1 !serial_clock; endproperty
    a_sck_half: assert property (p_sck_half) else $error("serial clock width");
    property p_sck_low; conversion_start |-> !serial_clock; endproperty
    a_sck_low: assert property (p_sck_low) else $error("clock in start");
    property p_pulse; $rose(conversion_start) |=> conversion_start ##1 !conversion_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse width");
    property p_rate; serial_clock |-> $stable(rate_select_pin); endproperty
    a_rate: assert property (p_rate) else $error("rate moved in frame");
    property p_count; $rose(conversion_start) |-> edges inside {0, 16, 32, 64, 128, 256}; endproperty
    a_count: assert property (p_count) else $error("frame edge count");
    property p_bound; serial_clock |-> edges < (rate_select_pin ? 128 : 256); endproperty
    a_bound: assert property (p_bound) else $error("frame too long");
endmodule

//--- bench/octal_adc_lane_serializer_test.sv
// Bench for the lane serializer: receiver and serializer joined over the link.
// Assumes the receiver makes the serial clock; results stay put within a frame.
module octal_adc_lane_serializer_test import oals_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic         sys_clk_i = 1'b0;
    logic         rstn_i    = 1'b0;
    logic         start_i   = 1'b0;
    logic         ddr_i     = 1'b0;
    logic         diff_i    = 1'b0;
    oals_lanes_t  lanes_i   = OALS_LANES_8;
    logic         busy_o;
    logic         done_o;
    oals_result_t res_in [OALS_NUM_CH];
    oals_result_t res_out [OALS_NUM_CH];
    logic [31:0]  lfsr = 32'h4756;
    int           exp_q [$];
    int           failures = 0;
    int           checks_done = 0;
    int           slot = 0;
    bit           live = 0;
    oals_link_if link ();
    oals_serializer i_oals_serializer (.rstn_i(rstn_i), .diff_mode_i(diff_i),
        .result_i(res_in), .link(link.device));
    oals_receiver i_oals_receiver (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .start_i(start_i),
        .ddr_i(ddr_i), .diff_mode_i(diff_i), .lanes_i(lanes_i), .busy_o(busy_o),
        .done_o(done_o), .result_o(res_out), .link(link.host));
    oals_link_assertions i_oals_link_assertions (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .serial_clock(link.serial_clock), .conversion_start(link.conversion_start),
        .rate_select_pin(link.rate_select_pin), .echo_clock(link.echo_clock), .lane(link.lane));
    always #10 sys_clk_i = ~sys_clk_i;
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic fail(string m);
        failures++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic check_bit(int l, logic got, logic want);
        checks_done++;
        if (got !== want) fail($sformatf("lane %0d slot %0d", l, slot));
    endtask
    task automatic check_res(int c, oals_result_t want);
        checks_done++;
        if (res_out[c] !== want) fail($sformatf("channel %0d result", c));
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Drives one frame; a second start while busy must be ignored.
    task automatic run_frame(logic ddr, logic diff, oals_lanes_t ln, logic bump);
        int n;
        live = 0;
        ddr_i = ddr;
        diff_i = diff;
        lanes_i = ln;
        for (int c = 0; c < OALS_NUM_CH; c++) begin
            lfsr = lfsr_next(lfsr);
            res_in[c] = lfsr[13:0];
            exp_q.push_back(int'(lfsr[13:0]));
        end
        start_i = 1'b1;
        @(posedge sys_clk_i) #1 start_i = 1'b0;
        if (bump) begin
            repeat (5) @(posedge sys_clk_i);
            #1 start_i = 1'b1;
            @(posedge sys_clk_i) #1 start_i = 1'b0;
        end
        for (n = 0; done_o !== 1'b1 && n < 2000; n++) @(posedge sys_clk_i) #1;
        if (n >= 2000) fail("no done");
        for (int c = 0; c < OALS_NUM_CH; c++) check_res(c, oals_result_t'(exp_q.pop_front()));
        @(posedge sys_clk_i) #1;
    endtask
    always @(posedge link.conversion_start) begin
        slot = 0;
        live = 1;
    end
    // Slot counts shifting edges: falling only in single rate, both in double rate.
    always @(link.serial_clock) if (live && (!link.serial_clock || link.rate_select_pin)) slot++;
    always @(negedge sys_clk_i) if (live && !link.conversion_start)
        for (int l = 0; l < OALS_NUM_CH; l += 1 + diff_i)
            check_bit(l, link.lane[l], res_in[(l + slot / OALS_RES_W) % OALS_NUM_CH]
                [OALS_RES_W - 1 - slot % OALS_RES_W]);
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        fail("watchdog");
        wrap_up;
    end
    initial begin
        foreach (res_in[c]) res_in[c] = 14'h0;
        repeat (2) @(posedge sys_clk_i);
        #1 rstn_i = 1'b1;
        @(posedge sys_clk_i) #1;
        for (int r = 0; r < 2; r++)
            for (int m = 0; m < 4; m++)
                for (int k = 0; k < 4; k++)
                    if (!(m[1] && k == 3)) run_frame(m[0], m[1], oals_lanes_t'(k), r[0]);
        wrap_up;
    end
endmodule

//--- hdl/oals_receiver.sv
// Receiver end: starts a conversion, divides sys_clk_i into the serial clock, and
// captures the chosen lanes back into eight results.
// Assumes the device loads its results while conversion_start is high.
module oals_receiver
    import oals_pkg::*;
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   start_i,
    input  wire logic                   ddr_i,
    input  wire logic                   diff_mode_i,
    input  wire oals_pkg::oals_lanes_t  lanes_i,
    output logic                        busy_o,
    output logic                        done_o,
    output oals_pkg::oals_result_t      result_o [oals_pkg::OALS_NUM_CH],
    oals_link_if.host                   link
);
    import oals_pkg::*;

    typedef enum logic [1:0] {
        OALS_IDLE  = 2'b00,
        OALS_START = 2'b01,
        OALS_SHIFT = 2'b10
    } oals_state_t;

    oals_state_t state;
    logic [1:0]  div;
    logic        sclk;
    logic [7:0]  bitpos;
    logic [OALS_FRAME_BITS-1:0] acc [OALS_NUM_CH];

    // Edges per frame: bits per lane; in SDR each is one full cycle.
    wire [7:0] lane_cnt   = 8'(1) << lanes_i;
    wire [7:0] bits_total = diff_mode_i ? (OALS_SDR_CYCLES_1 >> (lanes_i == OALS_LANES_1 ? 0 :
                            lanes_i == OALS_LANES_2 ? 1 : 2)) : (OALS_SDR_CYCLES_1 / lane_cnt);
    wire       div_tick   = (div == 2'(OALS_CLK_DIV / 2 - 1));
    wire       sample     = div_tick && (ddr_i || !sclk) && (bitpos != bits_total);
    // The frame ends only with the clock back low, so every high phase is full width.
    wire       frame_end  = (state == OALS_SHIFT) && div_tick && !sclk &&
                            (bitpos == bits_total);

    assign link.serial_clock     = sclk;
    assign link.conversion_start = (state == OALS_START);
    assign link.rate_select_pin  = ddr_i ? OALS_RATE_DDR : OALS_RATE_SDR;
    assign busy_o                = (state != OALS_IDLE);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state  <= OALS_IDLE;
            div    <= 2'h0;
            sclk   <= 1'b0;
            bitpos <= 8'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            div    <= div_tick ? 2'h0 : 2'(div + 2'h1);
            unique case (state)
                OALS_IDLE: begin
                    sclk   <= 1'b0;
                    div    <= 2'h0;
                    bitpos <= 8'h0;
                    if (start_i) begin
                        state <= OALS_START;
                    end
                end
                OALS_START: begin
                    if (div_tick) begin
                        state <= OALS_SHIFT;
                    end
                end
                OALS_SHIFT: begin
                    if (frame_end) begin
                        state  <= OALS_IDLE;
                        done_o <= 1'b1;
                    end else if (div_tick) begin
                        sclk <= !sclk;
                    end
                    // Data is sampled as sclk toggles: just before each shifting edge in DDR, just before each rising edge in SDR.
                    if (sample) begin
                        bitpos <= 8'(bitpos + 8'h1);
                    end
                end
                default: state <= OALS_IDLE;
            endcase
        end
    end

    // Each captured lane holds up to 8 results concatenated, first result on top.
    genvar k;
    generate
        for (k = 0; k < OALS_NUM_CH; k++) begin : g_cap
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    acc[k] <= '0;
                end else if (state == OALS_SHIFT && sample) begin
                    acc[k] <= {acc[k][OALS_FRAME_BITS-2:0], link.lane[k]};
                end
            end
        end
    endgenerate

    // Channel c comes from lane (c rounded down to the captured stride), result c - lane.
    generate
        for (k = 0; k < OALS_NUM_CH; k++) begin : g_out
            wire [2:0] stride_m = diff_mode_i ?
                                  3'((lanes_i == OALS_LANES_1) ? 0 : (lanes_i == OALS_LANES_2) ? 4 : 6)
                                : 3'(~((8'h8 >> lanes_i) - 8'h1));
            wire [2:0] src  = 3'(k) & stride_m;
            wire [2:0] idx  = 3'(k - src);
            // The first captured bit sits at bits_total - 1; trailing bits are dropped.
            wire [7:0] sh   = 8'(bits_total - 8'(OALS_RES_W) * (8'(idx) + 8'h1));
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    result_o[k] <= '0;
                end else if (frame_end) begin
                    result_o[k] <= OALS_RES_W'(acc[src] >> sh);
                end
            end
        end
    endgenerate
endmodule

//--- hdl/oals_serializer.sv
// Device end: loads eight results on conversion start and shifts them onto the lanes.
// Assumes results are stable when conversion_start falls; runs on the serial clock.
// Summary of operation
// - Single-ended capture on 8, 4, 2, 1 lanes
// - Differential capture on 4, 2, 1 pairs
// - Fourteen-bit results, most significant bit first
// - Each lane presents first MSB before readout
// - Lane k starts at channel k, wraps circularly
// - Pairs start at channels 1,3,5,7
// - Pairs continue circularly, wrapping after channel 8
// - Lane data identical whatever lanes are captured
// - Four lanes need 32 clocks or edges
// - Two lanes need 64 clocks or edges
// - One lane needs 128 clocks or edges
// - Two pairs need 64 clocks or edges
// - One pair needs 128 clocks or edges
// - Clocks per conversion are 128 or 64 over lanes
// - Period is pulse, conversion and readout times
// - Double rate halves the needed clock frequency
// - Fewer lanes lower the conversion rate
// - Shift on falling edge, or both in DDR
// - Rate pin low selects SDR, high DDR
// - Echo clock is serial clock aligned with data
module oals_serializer
    import oals_pkg::*;
(
    input  wire logic                        rstn_i,
    input  wire logic                        diff_mode_i,
    input  wire oals_pkg::oals_result_t      result_i [oals_pkg::OALS_NUM_CH],
    oals_link_if.device                      link
);
    import oals_pkg::*;

    // Loading on conversion start is asynchronous to the serial clock, which idles
    // between frames; the results are held static by the converter core.
    localparam int CYCLE_BITS = OALS_RES_W * OALS_NUM_CH;

    logic [6:0] rise_cnt;
    logic [6:0] fall_cnt;
    logic       ddr;

    assign ddr = (link.rate_select_pin == OALS_RATE_DDR);

    // Each edge half counts its own steps modulo one full circle of results; the
    // position is their sum, so neither half ever reads the other's register.
    wire [6:0] next_rise     = (rise_cnt == 7'(CYCLE_BITS - 1)) ? 7'h0 : 7'(rise_cnt + 7'h1);
    wire [6:0] next_fall     = (fall_cnt == 7'(CYCLE_BITS - 1)) ? 7'h0 : 7'(fall_cnt + 7'h1);
    wire [7:0] pos_sum       = 8'(rise_cnt) + 8'(fall_cnt);
    wire [6:0] position      = (pos_sum >= 8'(CYCLE_BITS)) ? 7'(pos_sum - 8'(CYCLE_BITS))
                                                           : 7'(pos_sum);
    wire [2:0] position_word = 3'(position / 7'(OALS_RES_W));
    wire [3:0] position_bit  = 4'(position % 7'(OALS_RES_W));

    // Rising-edge half: only advances in DDR.
    always_ff @(posedge link.serial_clock or negedge rstn_i or posedge link.conversion_start) begin
        if (!rstn_i || link.conversion_start) begin
            rise_cnt <= 7'h0;
        end else if (ddr) begin
            rise_cnt <= next_rise;
        end
    end

    // Falling-edge half: advances in both rates.
    always_ff @(negedge link.serial_clock or negedge rstn_i or posedge link.conversion_start) begin
        if (!rstn_i || link.conversion_start) begin
            fall_cnt <= 7'h0;
        end else begin
            fall_cnt <= next_fall;
        end
    end

    // Lane k shows channel (start + word) mod 8; with reset position zero each lane
    // already shows the MSB of its first result.
    genvar k;
    generate
        for (k = 0; k < OALS_NUM_CH; k++) begin : g_lane
            // pairs A-D are lanes 1,3,5,7 and start two channels apart.
            wire [2:0] start_ch = diff_mode_i ? 3'(k & 6) : 3'(k);
            wire [2:0] ch       = 3'(start_ch + position_word);
            wire [3:0] bsel     = 4'(OALS_MSB_IDX - position_bit);
            // same data on every lane whatever is captured.
            assign link.lane[k] = result_i[ch][bsel];
        end
    endgenerate

    // Echo clock is the serial clock passed straight through, with no added delay.
    assign link.echo_clock = link.serial_clock;
endmodule

//--- pkg/oals_link_if.sv
// Link between the converter serializer and its receiver.
// Assumes single-ended lanes; differential pairs reuse lanes 1,3,5,7 as pairs A-D.
interface oals_link_if;
    logic       serial_clock;
    logic       conversion_start;
    logic       rate_select_pin;
    logic       echo_clock;
    logic [7:0] lane;

    modport device (
        input  serial_clock,
        input  conversion_start,
        input  rate_select_pin,
        output echo_clock,
        output lane
    );
    modport host (
        output serial_clock,
        output conversion_start,
        output rate_select_pin,
        input  echo_clock,
        input  lane
    );
endinterface

//--- pkg/oals_pkg.sv
// Package for the octal converter lane serializer: widths, channel counts, lane orders.
// Assumes both ends import it; no timing other than the serial clock is modelled.
package oals_pkg;
    localparam int                  OALS_RES_W       = 14;
    localparam int                  OALS_NUM_CH      = 8;
    localparam int                  OALS_NUM_PAIR    = 4;
    localparam int                  OALS_CH_W        = 3;
    localparam int                  OALS_BIT_W       = 4;
    localparam logic [3:0]          OALS_MSB_IDX     = 4'hd;
    localparam int                  OALS_FRAME_BITS  = 128;
    localparam logic [7:0]          OALS_SDR_CYCLES_1 = 8'h80;
    localparam logic                OALS_RATE_SDR    = 1'b0;
    localparam logic                OALS_RATE_DDR    = 1'b1;
    localparam logic                OALS_MODE_SE     = 1'b0;
    localparam logic                OALS_MODE_DIFF   = 1'b1;
    localparam int                  OALS_CLK_DIV     = 4;

    typedef logic [OALS_RES_W-1:0] oals_result_t;

    typedef enum logic [1:0] {
        OALS_LANES_1 = 2'b00,
        OALS_LANES_2 = 2'b01,
        OALS_LANES_4 = 2'b10,
        OALS_LANES_8 = 2'b11
    } oals_lanes_t;
endpackage
